//--- bsc_seq.sv
// Burner sequence controller: start checks, purge, ignition, run, shut-off.
// Assumes contact inputs from the plant and actuator acks; durations in ticks.
// Behaviour
// RULE1: Nine digital burner control outputs.
// RULE2: On request, check interlock and air pressure.
// RULE3: Implausible fuel selection reports and halts start.
// RULE4: Checks pass: fan, vent on, actuators bottom.
// RULE5: Open actuators after bottom ack; leakage parallel.
// RULE6: Fuel back to ignition; purge needs acks.
// RULE7: Recirculation delay pauses purge until positioned.
// RULE8: Then ignition position, ack, gas pressure.
// RULE9: Transformer alone for pre-ignition time.
// RULE10: No pilot: main valves plus transformer, flame.
// RULE11: Pilot: staged valves over two safety periods.
// RULE12: After ignition, base load until release.
// RULE13: Release tracks load; withdrawal returns base/ignition.
// RULE14: Request removal closes gas stages 5 s apart.
// RULE15: Post-vent, after-burn, 5 s flame-off check.
// RULE16: Purge suppression input skips purge when enabled.
// RULE17: Auto suppression after regulator switch-off only.
// RULE18: Servicing: five starts unpurged, stop at stabilisation.
// RULE19: Program supervision time; zero disables.
// RULE20: Single delayed restart; zero suppresses; default off.
// RULE21: Fuel change: base load, shut down, switch, restart.
// RULE22: Learn travel limits on first purge after clear.
// RULE23: Timers count a common tick.
// RULE24: Fault drops fuel and ignition, latches signal.
`timescale 1ns/100ps
module bsc_seq
   import bsc_pkg::*;
#(
   parameter int NACT     = 4,
   parameter int TICK_DIV = TICK_CYC
) (
   input  wire logic            mclk_i,
   input  wire logic            resetn_i,
   input  wire logic            burner_on_i,
   input  wire logic            gas_lock_i,
   input  wire logic            oil_lock_i,
   input  wire logic            boiler_lock_i,
   input  wire logic            fuel_gas_i,
   input  wire logic            air_press_i,
   input  wire logic            gas_press_i,
   input  wire logic            flame_i,
   input  wire logic            ctrl_release_i,
   input  wire logic            purge_supp_i,
   input  wire logic            fault_reset_i,
   input  wire logic            ign_ack_i,
   input  wire logic            high_ack_i,
   input  wire logic [NACT-1:0] act_bottom_i,
   input  wire logic [NACT-1:0] act_top_i,
   input  wire logic [NACT-1:0] act_ign_i,
   input  wire logic            recirc_pos_i,
   input  wire logic            leak_busy_i,
   input  wire logic [9:0]      act_pos_i [NACT],
   input  wire logic            cfg_lock_fuel_i,
   input  wire logic            cfg_pilot_i,
   input  wire logic            cfg_recirc_i,
   input  wire logic            cfg_postvent_i,
   input  wire logic            cfg_base_i,
   input  wire logic            cfg_rel_ign_i,
   input  wire logic            cfg_supp_en_i,
   input  wire logic            cfg_auto_supp_i,
   input  wire logic            cfg_service_i,
   input  wire logic            cfg_restart_i,
   input  wire logic            clear_mem_i,
   input  wire logic [15:0]     t_purge_i,
   input  wire logic [15:0]     t_recirc_i,
   input  wire logic [15:0]     t_preign_i,
   input  wire logic [15:0]     t_safe1_i,
   input  wire logic [15:0]     t_safe2_i,
   input  wire logic [15:0]     t_postv_i,
   input  wire logic [15:0]     t_after_i,
   input  wire logic [15:0]     t_prog_i,
   input  wire logic [15:0]     t_restart_i,
   output logic [NOUT-1:0]      out_o,
   output bsc_pos_t             act_cmd_o,
   output logic                 recirc_open_o,
   output logic                 correction_en_o,
   output logic                 fuel_active_gas_o,
   output logic                 plaus_err_o,
   output logic [9:0]           lim_lo_o [NACT],
   output logic [9:0]           lim_hi_o [NACT],
   output logic                 lim_valid_o,
   output logic [15:0]          state_o
);
   // ------------------------------------------------
   // Input conditioning
   // ------------------------------------------------
   localparam int NSY = 15 + 3 * NACT; // Actuator acks are plant contacts too
   logic [NSY-1:0] raw, syn;
   logic tick;
   logic [NACT-1:0] bot_s, top_s, ign_s;
   assign raw = {burner_on_i, gas_lock_i, oil_lock_i, boiler_lock_i, fuel_gas_i, air_press_i,
                 gas_press_i, flame_i, ctrl_release_i, purge_supp_i, fault_reset_i, ign_ack_i,
                 high_ack_i, recirc_pos_i, leak_busy_i, act_bottom_i, act_top_i, act_ign_i};
   bsc_sync #(.W(NSY)) u_sync (.mclk_i(mclk_i), .resetn_i(resetn_i), .d_i(raw), .q_o(syn));
   bsc_tick #(.DIV(TICK_DIV)) u_tick (.mclk_i(mclk_i), .resetn_i(resetn_i), .tick_o(tick));
   logic on, glk, olk, blk, fgas, air, gpr, flm, rel, supp, frst, igk, hik, rcp, lkb;
   assign {on, glk, olk, blk, fgas, air, gpr, flm, rel, supp, frst, igk, hik, rcp, lkb, bot_s, top_s, ign_s} = syn;

   // ------------------------------------------------
   // State record
   // ------------------------------------------------
   typedef struct packed {
      bsc_state_t  state;
      logic [15:0] tmr;       // Phase timer in ticks
      logic [15:0] rtmr;      // Recirculation delay timer
      logic [15:0] ptmr;      // Program supervision timer
      logic        pmon;      // Supervision running
      logic        fuel;      // Latched fuel: 1 = gas
      logic        fault;     // Fault signal latched
      logic        ferr;      // Fault shut-off in progress
      logic        restart_used;
      logic        restart_pend;
      logic        reg_off;   // Last stop was a regulator switch-off
      logic        fchg;      // Fuel change pending
      logic [2:0]  svc_cnt;   // Unpurged starts since the last purge
      logic        plaus;
      logic        learned;
      logic [NACT-1:0][9:0] lo;
      logic [NACT-1:0][9:0] hi;
   } bsc_st_t;
   bsc_st_t st, next_st;

   logic lock_ok, plaus_ok, skip_purge, all_bot, all_top, all_ign, tdone, ign_ok, lim_ok;
   always_comb begin
      lock_ok  = blk && (fgas ? glk : olk);                          // [RULE2]
      plaus_ok = !cfg_lock_fuel_i || (glk ^ olk);                    // [RULE3]
      all_bot  = &bot_s;
      all_top  = &top_s;
      all_ign  = &ign_s;
      tdone    = (st.tmr == 16'h0000);
      ign_ok   = igk && (!fgas || gpr);                              // [RULE8]
      // Skip when suppressed by input, by auto mode, or by servicing budget
      skip_purge = st.learned && ((cfg_supp_en_i && supp)            // [RULE16]
                   || (cfg_auto_supp_i && st.reg_off)                 // [RULE17]
                   || (cfg_service_i && st.svc_cnt < 3'(SERVICE_STARTS))); // [RULE18]
      lim_ok = 1'b1;
      for (int i = 0; i < NACT; i++) begin
         if (st.learned && (act_pos_i[i] < st.lo[i] || act_pos_i[i] > st.hi[i]) && all_top)
            lim_ok = 1'b0;                                            // [RULE22]
      end
   end

   // ------------------------------------------------
   // Sequencer
   // ------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.plaus = 1'b0;
      if (tick && st.tmr != 16'h0000) next_st.tmr = st.tmr - 16'h0001;       // [RULE23]
      if (tick && st.rtmr != 16'h0000) next_st.rtmr = st.rtmr - 16'h0001;
      if (tick && st.pmon && st.ptmr != 16'h0000) next_st.ptmr = st.ptmr - 16'h0001;
      if (clear_mem_i) next_st.learned = 1'b0;
      if (st.state == S_OFF || st.state == S_CHECK) next_st.fuel = fgas;     // [RULE21]
      if (st.state != S_OFF && st.state != S_FAULT && !st.ferr && fgas != st.fuel)
         next_st.fchg = 1'b1;
      case (st.state)
         S_OFF: begin
            next_st.ferr = 1'b0;
            next_st.pmon = 1'b0; // An aborted start must not trip supervision later
            if (st.restart_pend && st.tmr == 16'h0000) next_st.restart_pend = 1'b0;
            if (on && !(st.restart_pend)) begin
               next_st.state = S_CHECK;
               next_st.ptmr  = t_prog_i;
               next_st.pmon  = (t_prog_i != 16'h0000);                        // [RULE19]
               next_st.fchg  = 1'b0;
            end
         end
         S_CHECK: begin
            if (!on) next_st.state = S_OFF;
            else if (!plaus_ok) next_st.plaus = 1'b1;                         // [RULE3]
            else if (lock_ok && air) begin
               if (skip_purge) begin
                  next_st.state = S_TOIGN;
                  next_st.svc_cnt = st.svc_cnt + 3'h1;
               end else begin
                  next_st.state = S_BOTTOM;                                   // [RULE4]
                  next_st.svc_cnt = 3'h0;
               end
               next_st.reg_off = 1'b0;
            end
         end
         S_BOTTOM: if (all_bot) next_st.state = S_TOP;                        // [RULE5]
         S_TOP: begin
            for (int i = 0; i < NACT; i++) begin
               if (!st.learned) begin
                  next_st.lo[i] = POS_MIN;
                  next_st.hi[i] = act_pos_i[i];                               // [RULE22]
               end
            end
            if (!lim_ok) next_st.ferr = 1'b1;
            else if (all_top && hik && air && !lkb) begin                     // [RULE6]
               next_st.state = S_PURGE;
               next_st.tmr   = t_purge_i;
               next_st.rtmr  = t_recirc_i;
               next_st.learned = 1'b1;
            end
         end
         S_PURGE: begin
            // Hold the purge count while recirculation travels  [RULE7]
            if (cfg_recirc_i && st.rtmr == 16'h0000 && !rcp) next_st.tmr = st.tmr;
            if (!air) next_st.ferr = 1'b1;
            else if (tdone) next_st.state = S_TOIGN;
         end
         S_TOIGN: if (all_ign && ign_ok) begin                                // [RULE8]
            next_st.state = S_PREIGN;
            next_st.tmr   = t_preign_i;
         end
         S_PREIGN: if (tdone) begin                                           // [RULE9]
            next_st.state = S_SAFE1;
            next_st.tmr   = t_safe1_i;
         end
         S_SAFE1: if (tdone) begin
            if (!flm) next_st.ferr = 1'b1;                                    // [RULE10]
            else if (cfg_pilot_i) begin
               next_st.state = S_SAFE2;                                       // [RULE11]
               next_st.tmr   = t_safe2_i;
            end else next_st.state = S_BASE;
         end
         S_SAFE2: if (tdone) next_st.state = S_BASE;
         S_BASE: begin
            next_st.pmon = 1'b0;
            if (cfg_service_i) next_st.state = S_BASE;                        // [RULE18]
            else if (rel && !st.fchg) next_st.state = S_RUN;                  // [RULE12]
         end
         S_RUN: if (!rel || st.fchg) next_st.state = S_BASE;                  // [RULE13]
         S_STAGE: if (tdone) begin                                            // [RULE14]
            next_st.state = cfg_postvent_i ? S_POSTV : S_AFTER;
            next_st.tmr   = cfg_postvent_i ? t_postv_i : t_after_i;
         end
         S_POSTV: if (tdone) begin                                            // [RULE15]
            next_st.state = S_AFTER;
            next_st.tmr   = t_after_i;
         end
         S_AFTER: if (tdone) begin
            next_st.state = S_FLCHK;
            next_st.tmr   = FLAME_OFF_TK;
         end
         S_FLCHK: begin
            if (flm) next_st.ferr = 1'b1;                                     // [RULE15]
            else if (tdone) next_st.state = S_OFF;
         end
         S_FAULT: begin
            if (cfg_restart_i && t_restart_i != 16'h0000 && !st.restart_used) begin
               next_st.restart_used = 1'b1;                                   // [RULE20]
               next_st.restart_pend = 1'b1;
               next_st.fault = 1'b0;
               next_st.tmr   = t_restart_i;
               next_st.state = S_OFF;
            end else if (frst) begin
               next_st.fault = 1'b0;                                          // [RULE24]
               next_st.state = S_OFF;
            end
         end
         default: next_st.state = S_OFF;
      endcase
      // Normal stop: request removed or fuel change reached base load
      if ((st.state == S_BASE || st.state == S_RUN) && (!on || (st.fchg && st.state == S_BASE))) begin
         next_st.state = S_STAGE;                                             // [RULE21]
         next_st.tmr   = st.fuel ? GAS_STAGE_TK : 16'h0000;
         next_st.reg_off = !st.fchg;
         next_st.restart_used = 1'b0;
      end
      if (st.state inside {S_BOTTOM, S_TOP, S_PURGE, S_TOIGN, S_PREIGN} && !on)
         next_st.state = S_OFF;
      if (st.pmon && st.ptmr == 16'h0000 && st.state != S_OFF) next_st.ferr = 1'b1; // [RULE19]
      // A fault takes over in this same cycle; all fuel drops at once
      if (next_st.ferr && st.state != S_FAULT) begin
         next_st.ferr  = 1'b0;
         next_st.fault = 1'b1;                                                // [RULE24]
         next_st.pmon  = 1'b0;
         next_st.reg_off = 1'b0;                                              // [RULE17]
         next_st.state = S_FAULT;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st       <= '0;
         st.state <= S_OFF;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------
   // Outputs; fuel bits are gated off whenever fault is set
   // ------------------------------------------------
   logic fuel_on;
   always_comb begin
      fuel_on = (st.state inside {S_SAFE1, S_SAFE2, S_BASE, S_RUN}) && !st.fault;
      out_o = '0;                                                              // [RULE1]
      out_o[O_FAN]   = !(st.state inside {S_OFF, S_CHECK, S_FAULT});            // [RULE4]
      out_o[O_VENT]  = st.state inside {S_BOTTOM, S_TOP, S_PURGE, S_POSTV};
      out_o[O_IGNT]  = (st.state == S_PREIGN) || (st.state == S_SAFE1);        // [RULE9]
      out_o[O_IGNV]  = fuel_on && cfg_pilot_i && (st.state inside {S_SAFE1, S_SAFE2}); // [RULE11]
      out_o[O_GAS1]  = fuel_on && st.fuel;
      out_o[O_GAS2]  = st.fuel && !st.fault &&
                       ((fuel_on && (!cfg_pilot_i || st.state != S_SAFE1)) || st.state == S_STAGE); // [RULE14]
      out_o[O_OIL]   = fuel_on && !st.fuel;                                    // [RULE10]
      out_o[O_FAULT] = st.fault;                                               // [RULE24]
      out_o[O_GASOP] = st.fuel;
      if (st.state == S_BOTTOM)                                   act_cmd_o = BSC_POS_BOTTOM;
      else if (st.state == S_TOP || st.state == S_PURGE || st.state == S_POSTV) act_cmd_o = BSC_POS_TOP;
      else if (st.state == S_RUN)                                 act_cmd_o = BSC_POS_LOAD;
      else if (st.state == S_BASE && (cfg_base_i && !(cfg_rel_ign_i && !rel))) act_cmd_o = BSC_POS_BASE;
      else if (st.state == S_OFF || st.state == S_FAULT)          act_cmd_o = BSC_POS_HOLD;
      else                                                        act_cmd_o = BSC_POS_IGN;
   end
   assign recirc_open_o     = cfg_recirc_i && ((st.state == S_PURGE && st.rtmr == 16'h0000)
                              || st.state inside {S_BASE, S_RUN});             // [RULE7]
   assign correction_en_o   = st.state inside {S_BASE, S_RUN};                 // [RULE12]
   assign fuel_active_gas_o = st.fuel;
   assign plaus_err_o       = st.plaus;
   assign lim_valid_o       = st.learned;
   assign state_o           = st.state;
   for (genvar g = 0; g < NACT; g++) begin : g_lim
      assign lim_lo_o[g] = st.learned ? st.lo[g] : POS_MIN;
      assign lim_hi_o[g] = st.learned ? st.hi[g] : POS_MAX;
   end

   // ------------------------------------------------
   // Checks
   // ------------------------------------------------
   sequence fault_entry_s;
      st.state != S_FAULT ##1 st.state == S_FAULT;
   endsequence
   fault_drop_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE24]
      fault_entry_s |-> !out_o[O_GAS1] && !out_o[O_GAS2] && !out_o[O_OIL] && !out_o[O_IGNT] && out_o[O_FAULT])
      else $error("fuel outputs not dropped on fault");
   fault_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE24]
      out_o[O_FAULT] && !frst && !cfg_restart_i |=> out_o[O_FAULT])
      else $error("fault signal released without reset");
   preign_alone_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE9]
      st.state == S_PREIGN |-> out_o[O_IGNT] && !out_o[O_GAS1] && !out_o[O_OIL] && !out_o[O_IGNV])
      else $error("fuel valve open during pre-ignition");
   check_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE2]
      st.state == S_CHECK && !air |=> st.state != S_BOTTOM && st.state != S_TOIGN)
      else $error("start left check without air pressure");
   purge_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE6]
      st.state == S_TOP ##1 st.state == S_PURGE |-> $past(hik) && $past(air))
      else $error("purge started without acknowledgements");
   flame_fail_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE15]
      st.state == S_FLCHK && flm |=> st.state == S_FAULT)
      else $error("flame present after shut-off not faulted");
   stage_close_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE14]
      st.state == S_STAGE |-> !out_o[O_GAS1])
      else $error("stage one open during shut-off");
   ign_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [RULE8]
      st.state == S_TOIGN ##1 st.state == S_PREIGN |-> $past(igk) && $past(all_ign))
      else $error("ignition without position acknowledgement");
endmodule

//--- bsc_pkg.sv
// Package for the burner sequence controller: output bits, states, timing.
// Assumes a 10 MHz system clock; all durations count in 100 ms ticks.
package bsc_pkg;
   // --------------------------------------------------------------
   // Clock and tick
   // --------------------------------------------------------------
   localparam int  CLK_HZ          = 10000000;
   localparam int  TICK_MS         = 100;
   localparam int  TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
   localparam int  GAS_STAGE_MS    = 5000;
   localparam int  FLAME_OFF_MS    = 5000;
   localparam int  RESTART_MS      = 10000;
   localparam logic [15:0] GAS_STAGE_TK  = 16'(GAS_STAGE_MS / TICK_MS);
   localparam logic [15:0] FLAME_OFF_TK  = 16'(FLAME_OFF_MS / TICK_MS);
   localparam logic [15:0] RESTART_TK    = 16'(RESTART_MS / TICK_MS);
   localparam int  SERVICE_STARTS  = 5;
   localparam logic [9:0] POS_MIN  = 10'h000;
   localparam logic [9:0] POS_MAX  = 10'h3e7;
   // --------------------------------------------------------------
   // Output bit positions (nine outputs)
   // --------------------------------------------------------------
   localparam int  NOUT     = 9;
   localparam int  O_GAS1   = 0;
   localparam int  O_GAS2   = 1;
   localparam int  O_OIL    = 2;
   localparam int  O_IGNV   = 3;
   localparam int  O_IGNT   = 4;
   localparam int  O_FAN    = 5;
   localparam int  O_VENT   = 6;
   localparam int  O_FAULT  = 7;
   localparam int  O_GASOP  = 8;
   // Actuator targets
   typedef enum logic [2:0] {
      BSC_POS_HOLD = 3'h0, BSC_POS_BOTTOM = 3'h1, BSC_POS_TOP = 3'h2,
      BSC_POS_IGN = 3'h3, BSC_POS_BASE = 3'h4, BSC_POS_LOAD = 3'h5
   } bsc_pos_t;
   // Sequencer states
   typedef enum logic [15:0] {
      S_OFF     = 16'h0001, S_CHECK   = 16'h0002, S_BOTTOM  = 16'h0004,
      S_TOP     = 16'h0008, S_PURGE   = 16'h0010, S_TOIGN   = 16'h0020,
      S_PREIGN  = 16'h0040, S_SAFE1   = 16'h0080, S_SAFE2   = 16'h0100,
      S_BASE    = 16'h0200, S_RUN     = 16'h0400, S_STAGE   = 16'h0800,
      S_POSTV   = 16'h1000, S_AFTER   = 16'h2000, S_FLCHK   = 16'h4000,
      S_FAULT   = 16'h8000
   } bsc_state_t;
endpackage

//--- bsc_tick.sv
// Tick divider: one-cycle enable every DIV system clocks, TICK_CYC by default.
// Assumes the single system clock domain.
`timescale 1ns/100ps
module bsc_tick
   import bsc_pkg::*;
#(
   parameter int DIV = TICK_CYC
) (
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   output logic      tick_o
);
   typedef struct packed { logic [23:0] cnt; logic tick; } bsc_tk_t;
   bsc_tk_t st, next_st;
   // ------------------------------------------------
   // Divider
   // ------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 24'(DIV - 1)) begin
         next_st.cnt  = '0;
         next_st.tick = 1'b1; // Common base of every timer [RULE23]
      end else begin
         next_st.cnt = st.cnt + 24'h000001;
      end
   end
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) st <= '0;
      else           st <= next_st;
   end
   assign tick_o = st.tick;
endmodule

//--- bsc_sync.sv
// Two-flop synchroniser bank for the contact inputs.
// Assumes inputs are asynchronous floating contacts.
`timescale 1ns/100ps
module bsc_sync #(
   parameter int W = 16
) (
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed { logic [W-1:0] s1; logic [W-1:0] s2; } bsc_sy_t;
   bsc_sy_t st, next_st;
   // ------------------------------------------------
   // Two stages; only the second is read outside
   // ------------------------------------------------
   always_comb begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) st <= '0;
      else           st <= next_st;
   end
   assign q_o = st.s2;
endmodule

//--- bsc_plant.sv
// Plant model: actuators, position acks, pressure monitors and flame.
// Assumes the sequencer's actuator target and output bits as inputs.
`timescale 1ns/100ps
module bsc_plant
   import bsc_pkg::*;
#(
   parameter int NACT = 2
) (
   input  wire logic            mclk_i,
   input  wire bsc_pos_t        act_cmd_i,
   input  wire logic [NOUT-1:0] out_i,
   output logic [NACT-1:0]      bot_o,
   output logic [NACT-1:0]      top_o,
   output logic [NACT-1:0]      ign_o,
   output logic [9:0]           pos_o [NACT],
   output logic                 high_o,
   output logic                 ignack_o,
   output logic                 air_o,
   output logic                 gas_o,
   output logic                 flame_o
);
   bsc_pos_t pos = BSC_POS_HOLD;
   // Actuators settle one cycle after a new target; hold keeps the last place
   always @(posedge mclk_i) begin
      if (act_cmd_i != BSC_POS_HOLD) pos <= act_cmd_i;
      flame_o <= out_i[O_GAS1] | out_i[O_OIL];
   end
   // Standing draught: the sequencer wants the air monitor closed before the fan runs
   assign air_o    = 1'b1;
   assign bot_o    = {NACT{pos == BSC_POS_BOTTOM}};
   assign top_o    = {NACT{pos == BSC_POS_TOP}};
   assign ign_o    = {NACT{pos == BSC_POS_IGN}};
   assign high_o   = (pos == BSC_POS_TOP);
   assign ignack_o = (pos == BSC_POS_IGN);
   assign gas_o    = 1'b1;
   assign pos_o    = '{default: (pos == BSC_POS_TOP) ? 10'h3e7 : 10'h000};
endmodule

//--- test_bsc_seq.sv
// Testbench for the burner sequencer: start checks and the start sequence.
// Assumes zero-length durations except a two-tick first safety time so the run stays short.
`timescale 1ns/100ps
module test_bsc_seq import bsc_pkg::*; ;
   logic mclk_i = 0, resetn_i = 0, burner_on_i = 0, gas_lock_i = 1, oil_lock_i = 0;
   logic boiler_lock_i = 1, fuel_gas_i = 1, ctrl_release_i = 0, purge_supp_i = 0, fault_reset_i = 0;
   logic recirc_pos_i = 1, leak_busy_i = 0, cfg_lock_fuel_i = 1, cfg_pilot_i = 0, cfg_recirc_i = 0;
   logic cfg_postvent_i = 0, cfg_base_i = 0, cfg_rel_ign_i = 0, cfg_supp_en_i = 0, cfg_auto_supp_i = 0;
   logic cfg_service_i = 0, cfg_restart_i = 0, clear_mem_i = 0;
   logic air_press_i, gas_press_i, flame_i, ign_ack_i, high_ack_i, recirc_open_o, correction_en_o;
   logic fuel_active_gas_o, plaus_err_o, lim_valid_o;
   logic [15:0] t_purge_i = 0, t_recirc_i = 0, t_preign_i = 0, t_safe1_i = 2, t_safe2_i = 0;
   logic [15:0] t_postv_i = 0, t_after_i = 0, t_prog_i = 0, t_restart_i = 0, state_o;
   logic [1:0]  act_bottom_i, act_top_i, act_ign_i;
   logic [9:0]  act_pos_i [2], lim_lo_o [2], lim_hi_o [2];
   logic [NOUT-1:0] out_o;
   bsc_pos_t    act_cmd_o;
   int          miscompares = 0, checks = 0, cyc = 0;
   bsc_seq #(.NACT(2), .TICK_DIV(10)) dut (.*);
   bsc_plant #(.NACT(2)) plant (.mclk_i(mclk_i), .act_cmd_i(act_cmd_o), .out_i(out_o), .bot_o(act_bottom_i),
      .top_o(act_top_i), .ign_o(act_ign_i), .pos_o(act_pos_i), .high_o(high_ack_i), .ignack_o(ign_ack_i),
      .air_o(air_press_i), .gas_o(gas_press_i), .flame_o(flame_i));
   // ------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // ------------------------------------------------------------
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   // Ceiling well above the roughly 1100 cycles the tests need
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 90000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait for a sequencer state, then compare it
   task automatic wt(input bsc_state_t s);
      int n = 0;
      while (state_o !== s && n < 3000) begin
         @(posedge mclk_i);
         #10;
         n++;
      end
      chk(state_o, s);
   endtask
   task automatic rst();
      resetn_i = 0;
      repeat (20) @(posedge mclk_i);
      #10 resetn_i = 1;
      chk(16'(out_o), 16'h0000);
      chk(state_o, S_OFF);
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Both fuel chains closed while gas is chosen must hold the start
   task automatic implausible_fuel();
      oil_lock_i = 1;
      burner_on_i = 1;
      wt(S_CHECK);
      repeat (10) @(posedge mclk_i);
      #10 chk(state_o, S_CHECK);
      chk(16'(plaus_err_o), 16'h0001);
      oil_lock_i = 0;
      burner_on_i = 0;
   endtask
   // Full start without pilot through modulating run and staged shut-off
   task automatic normal_start();
      burner_on_i = 1;
      wt(S_BOTTOM);
      chk(16'({out_o[O_FAN], out_o[O_VENT]}), 16'h0003);
      chk(16'(act_cmd_o), 16'(BSC_POS_BOTTOM));
      wt(S_TOP);
      wt(S_PREIGN);
      chk(16'(out_o) & 16'h001f, 16'h0010);
      wt(S_SAFE1);
      chk(16'({out_o[O_GAS1], out_o[O_IGNT]}), 16'h0003);
      wt(S_BASE);
      chk(16'(act_cmd_o), 16'(BSC_POS_IGN));
      #1000 ctrl_release_i = 1;
      wt(S_RUN);
      chk(16'(act_cmd_o), 16'(BSC_POS_LOAD));
      chk(16'(correction_en_o), 16'h0001);
      chk(16'(lim_valid_o), 16'h0001);
      chk(16'(lim_hi_o[0]), 16'h03e7);
      burner_on_i = 0;
      wt(S_STAGE);
      chk(16'(out_o) & 16'h0003, 16'h0002);
      wt(S_OFF);
   endtask
   initial begin
      rst();
      implausible_fuel();
      rst();
      normal_start();
      report_and_stop();
   end
endmodule
